// ### logic/dbu_map.svh
`ifndef DBU_MAP_SVH
`define DBU_MAP_SVH

// ----------------------------------------------------------------------
// Channel counts and widths
// ----------------------------------------------------------------------
`define DBU_GAMMA_CHANNELS 14
`define DBU_ALL_CHANNELS   16
`define DBU_CODE_BITS      10
`define DBU_MAX_SETS       5'h14

// ----------------------------------------------------------------------
// Channel address codes
// ----------------------------------------------------------------------
`define DBU_ADDR_GAMMA_LAST 5'h0D
`define DBU_ADDR_COMMON_A   5'h12
`define DBU_ADDR_COMMON_B   5'h13
`define DBU_ADDR_WR_DISABLE 5'h14

// ----------------------------------------------------------------------
// Data word fields
// ----------------------------------------------------------------------
`define DBU_XFER_BIT      15
`define DBU_MODE_MSB      15
`define DBU_MODE_LSB      14
`define DBU_MODE_OTP      2'h1
`define DBU_WR_DISABLE_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DBU_CODE_RESET 10'h000

`endif

// ### logic/dbu_pkg.sv
package dbu_pkg;
    typedef logic [9:0] dbu_code_t;
    typedef logic [4:0] dbu_addr_t;
    typedef logic [3:0] dbu_index_t;
endpackage

// ### logic/dbu_update.sv
// Contract
// - New codes land in first register bank.
// - Outputs hold while data only preloaded.
// - Bit 15 write moves all channels.
// - Load strobe pin moves all channels.
// - Software move follows the triggering word.
// - Power-up outputs take stored OTP codes.
// - Common channels write without touching gamma.
// - Permanent OTP storage for all channels.
// - Sixteen channels: fourteen gamma, two common.
// - Acknowledge only the valid address codes.
// - Write-disable bit blocks further OTP writes.
// - Sequential writes step; twenty sets, skip four.
`timescale 1ns/1ns
`default_nettype none
`include "dbu_map.svh"

module dbu_update
    import dbu_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         otp_blank_init,
    input  wire logic         load_strobe_pin,
    input  wire logic         bus_start,
    input  wire logic [4:0]   bus_addr,
    input  wire logic         bus_word,
    input  wire logic [15:0]  bus_data,
    output logic              addr_ack,
    output logic [139:0]      gamma_code_out,
    output logic [9:0]        common_electrode_out_a,
    output logic [9:0]        common_electrode_out_b,
    output logic              otp_locked,
    output logic [9:0]        read_code
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // OTP cells keep their value through srst; only a blank-part init
    // clears them, standing in for a never-programmed device.
    dbu_code_t otp_cell   [`DBU_ALL_CHANNELS];
    dbu_code_t first_bank [`DBU_ALL_CHANNELS];
    dbu_code_t out_bank   [`DBU_ALL_CHANNELS];
    logic      otp_wr_off;

    // ------------------------------------------------------------------
    // Load strobe synchroniser
    // ------------------------------------------------------------------
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;

    always_ff @(posedge core_clk) begin
        strobe_s1 <= load_strobe_pin;
        strobe_s2 <= strobe_s1;
        strobe_s3 <= strobe_s2;
    end

    // The pin is idle high; a falling edge requests the move.
    // Two flops settle the pin first; the third only remembers the last
    // settled level, so a metastable sample never reaches the banks.
    wire pin_load = strobe_s3 & ~strobe_s2;

    // ------------------------------------------------------------------
    // Address pointer for single and sequential writes
    // ------------------------------------------------------------------
    dbu_addr_t ptr;
    logic      seq_open;
    logic      first_word;
    logic [4:0] set_count;

    wire addr_gamma = bus_addr <= `DBU_ADDR_GAMMA_LAST;
    wire addr_common = (bus_addr == `DBU_ADDR_COMMON_A) |
                       (bus_addr == `DBU_ADDR_COMMON_B);
    wire addr_valid = addr_gamma | addr_common |
                      (bus_addr == `DBU_ADDR_WR_DISABLE);

    // The pointer keeps stepping over the discarded sets; the set count, or a
    // word at the write-disable address, closes a long sequential write.
    wire ptr_gamma = ptr <= `DBU_ADDR_GAMMA_LAST;
    wire ptr_common = (ptr == `DBU_ADDR_COMMON_A) | (ptr == `DBU_ADDR_COMMON_B);
    wire word_ok = bus_word & seq_open & (set_count < `DBU_MAX_SETS);
    wire chan_hit = word_ok & (ptr_gamma | ptr_common);
    wire dis_hit = word_ok & first_word & (ptr == `DBU_ADDR_WR_DISABLE);
    wire [3:0] chan_idx = ptr_gamma ? ptr[3:0] : {3'h7, ptr[0]};

    // ------------------------------------------------------------------
    // Data word decode
    // ------------------------------------------------------------------
    // An OTP word to a channel, unless otp_wr_off is set, also moves every output, so the banks never disagree
    // with what was just burnt into the cells.
    wire [1:0] word_mode = bus_data[`DBU_MODE_MSB:`DBU_MODE_LSB];
    wire       otp_mode  = word_mode == `DBU_MODE_OTP;
    wire       xfer_req  = bus_data[`DBU_XFER_BIT];
    wire       otp_write = chan_hit & otp_mode & ~otp_wr_off;
    wire       sw_load   = chan_hit & ~otp_mode & xfer_req;
    wire [9:0] word_code = bus_data[9:0];

    // ------------------------------------------------------------------
    // Move request
    // ------------------------------------------------------------------
    // One shared strobe feeds every channel, so all outputs change on the
    // same edge and no mix of old and new codes is ever shown.
    wire       move_all  = sw_load | pin_load | otp_write;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            seq_open   <= 1'b0;
            first_word <= 1'b0;
            ptr        <= 5'h00;
            set_count  <= 5'h00;
            addr_ack   <= 1'b0;
        end else if (bus_start) begin
            seq_open   <= addr_valid;
            first_word <= 1'b1;
            ptr        <= bus_addr;
            set_count  <= 5'h00;
            addr_ack   <= addr_valid;
        end else begin
            addr_ack <= 1'b0;
            if (word_ok) begin
                first_word <= 1'b0;
                ptr        <= ptr + 5'h01;
                set_count  <= set_count + 5'h01;
                if (ptr == `DBU_ADDR_WR_DISABLE) begin
                    seq_open <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Write-disable bit
    // ------------------------------------------------------------------
    // The lock only falls to a blank-part init; srst leaves it set, as a
    // burnt fuse would.
    wire dis_set = dis_hit & otp_mode & bus_data[`DBU_WR_DISABLE_BIT];

    always_ff @(posedge core_clk) begin
        if (otp_blank_init) begin
            otp_wr_off <= 1'b0;
        end else if (dis_set) begin
            otp_wr_off <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel banks
    // ------------------------------------------------------------------
    // The output copy reads the next first-bank value, so a bit-15 word
    // lands in its own channel and moves all outputs on the same edge.
    genvar ch;
    generate
        for (ch = 0; ch < `DBU_ALL_CHANNELS; ch = ch + 1) begin : g_chan
            wire sel = chan_hit & (chan_idx == 4'(ch));
            wire sel_otp = sel & otp_write;
            wire [9:0] next_otp = otp_cell[ch] | word_code;
            wire [9:0] next_first = sel_otp ? next_otp :
                                    (sel & ~otp_mode) ? word_code : first_bank[ch];

            // Cells only gain ones; only a blank-part init clears a set bit again.
            always_ff @(posedge core_clk) begin
                if (otp_blank_init) begin
                    otp_cell[ch] <= `DBU_CODE_RESET;
                end else if (sel_otp) begin
                    otp_cell[ch] <= next_otp;
                end
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    first_bank[ch] <= otp_cell[ch];
                    out_bank[ch]   <= otp_cell[ch];
                end else begin
                    first_bank[ch] <= next_first;
                    if (move_all) begin
                        out_bank[ch] <= next_first;
                    end
                end
            end

            if (ch < `DBU_GAMMA_CHANNELS) begin : g_gamma
                always_ff @(posedge core_clk) begin
                    gamma_code_out[ch*10 +: 10] <= out_bank[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status and readback
    // ------------------------------------------------------------------
    // Readback shows the output bank, so a preload that has not been
    // moved yet stays invisible here.
    wire       read_chan = ptr_gamma | ptr_common;
    wire       read_dis  = ptr == `DBU_ADDR_WR_DISABLE;
    wire [9:0] read_next = read_chan ? out_bank[chan_idx] :
                           read_dis ? {9'h000, otp_wr_off} :
                           `DBU_CODE_RESET;

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    // Every port leaves from a flop; the extra cycle of latency is the
    // price of clean edges at the pins.
    always_ff @(posedge core_clk) begin
        common_electrode_out_a <= out_bank[14];
        common_electrode_out_b <= out_bank[15];
        otp_locked             <= otp_wr_off;
        read_code              <= read_next;
    end

endmodule

`default_nettype wire

// ### verif/dbu_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbu_host_model (
    input  wire logic   core_clk,
    output logic        load_strobe_pin,
    output logic        bus_start,
    output logic [4:0]  bus_addr,
    output logic        bus_word,
    output logic [15:0] bus_data
);
    initial begin
        load_strobe_pin = 1'b1;
        bus_start = 1'b0;
        bus_word = 1'b0;
        bus_addr = 5'h00;
        bus_data = 16'h0000;
    end
    // Consumed fields are inverted so a stale value never passes for a fresh one.
    task automatic put(input logic cmd, input logic [4:0] a, input logic [15:0] d, input int gap);
        repeat (gap + 1) @(posedge core_clk);
        bus_start <= #1 cmd;
        bus_word <= #1 !cmd;
        bus_addr <= #1 a;
        bus_data <= #1 d;
        @(posedge core_clk);
        bus_start <= #1 1'b0;
        bus_word <= #1 1'b0;
        bus_addr <= #1 ~a;
        bus_data <= #1 ~d;
    endtask
    task automatic strobe();
        @(posedge core_clk);
        load_strobe_pin <= #1 1'b0;
        repeat (2) @(posedge core_clk);
        load_strobe_pin <= #1 1'b1;
    endtask
endmodule
`default_nettype wire

// ### verif/dbu_update_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dbu_update_properties (
    input wire logic         core_clk,
    input wire logic         srst,
    input wire logic         otp_blank_init,
    input wire logic         load_strobe_pin,
    input wire logic         bus_start,
    input wire logic [4:0]   bus_addr,
    input wire logic         bus_word,
    input wire logic [15:0]  bus_data,
    input wire logic         addr_ack,
    input wire logic [139:0] gamma_code_out,
    input wire logic [9:0]   common_electrode_out_a,
    input wire logic [9:0]   common_electrode_out_b,
    input wire logic         otp_locked
);
    wire        vld = bus_addr <= 5'h0D || (bus_addr >= 5'h12 && bus_addr <= 5'h14);
    logic [3:0] quiet;
    // Any cause of a move restarts the count; the pin path needs four cycles to land.
    always_ff @(posedge core_clk) begin
        if (srst || otp_blank_init || !load_strobe_pin || (bus_word && |bus_data[15:14])) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    ack_valid_a: assert property (bus_start && vld |=> addr_ack)
        else $error("no ack");
    ack_invalid_a: assert property (bus_start && !vld |=> !addr_ack)
        else $error("bad ack");
    ack_cause_a: assert property (addr_ack |-> $past(bus_start) && $past(vld))
        else $error("stray ack");
    ack_pulse_a: assert property (addr_ack && !bus_start |=> !addr_ack)
        else $error("long ack");
    gamma_hold_a: assert property (quiet > 4'h7 |-> $stable(gamma_code_out))
        else $error("gamma moved");
    common_hold_a: assert property (quiet > 4'h7 |->
        $stable({common_electrode_out_a, common_electrode_out_b}))
        else $error("common moved");
    lock_keep_a: assert property (otp_locked && !otp_blank_init |=> otp_locked)
        else $error("lock lost");
    lock_cause_a: assert property ($rose(otp_locked) && !$past(srst) |->
        $past(bus_word) || $past(bus_word, 2))
        else $error("lock without word");
endmodule
`default_nettype wire

// ### verif/test_dbu_update.sv
`timescale 1ns/1ns
`default_nettype none
module test_dbu_update;
    import dbu_pkg::*;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic              otp_blank_init = 1'b1;
    wire logic         load_strobe_pin, bus_start, bus_word, addr_ack, otp_locked;
    wire logic [4:0]   bus_addr;
    wire logic [9:0]   read_code;
    logic [9:0]        code;
    int                otp[16];
    wire logic [15:0]  bus_data;
    wire logic [139:0] gamma_code_out;
    wire dbu_code_t    common_electrode_out_a, common_electrode_out_b;
    wire logic [159:0] all_out = {common_electrode_out_b, common_electrode_out_a, gamma_code_out};
    int                first_bank[16], out_bank[16], num_errors = 0, checks_done = 0;
    always #50 core_clk = ~core_clk;
    dbu_host_model host (.core_clk, .load_strobe_pin, .bus_start, .bus_addr, .bus_word, .bus_data);
    dbu_update DUT (.core_clk, .srst, .otp_blank_init, .load_strobe_pin, .bus_start, .bus_addr,
        .bus_word, .bus_data, .addr_ack, .gamma_code_out, .common_electrode_out_a,
        .common_electrode_out_b, .otp_locked, .read_code);
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check_all();
        repeat (6) @(posedge core_clk);
        #1;
        for (int i = 0; i < 16; i++) begin
            check(all_out[i*10+:10], 10'(out_bank[i]));
        end
    endtask
    // Gamma codes use pointers 0..13, the two common channels pointers 18 and 19.
    task automatic send(input logic [4:0] a, input int n, input logic xfer);
        int p;
        logic [15:0] d;
        p = (a == 5'h0E) ? 99 : a;
        host.put(1'b1, a, 16'h0000, 0);
        for (int i = 0; i < n; i++) begin
            d = {xfer && i == n - 1, 5'h00, 10'($urandom)};
            host.put(1'b0, 5'h00, d, $urandom_range(2));
            if (p < 14 || p == 18 || p == 19) first_bank[p < 14 ? p : p - 4] = d[9:0];
            if (d[15] && p < 99) out_bank = first_bank;
            p++;
        end
        check_all();
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(69288));
        repeat (3) @(posedge core_clk);
        #1 otp_blank_init = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        check_all();
        send(5'h00, 14, 1'b0);
        send(5'h12, 2, 1'b0);
        host.strobe();
        out_bank = first_bank;
        check_all();
        send(5'h0E, 2, 1'b1);
        send(5'h00, 14, 1'b1);
        send(5'h00, 20, 1'b1);
        send(5'h07, 1, 1'b1);
        code = 10'($urandom);
        host.put(1'b1, 5'h03, 16'h0000, 0);
        host.put(1'b0, 5'h00, {6'h10, code}, 0);
        otp[3] = otp[3] | code;
        first_bank[3] = otp[3];
        out_bank = first_bank;
        check_all();
        @(posedge core_clk);
        #1 srst = 1'b1;
        @(posedge core_clk);
        #1 srst = 1'b0;
        first_bank = otp;
        out_bank = otp;
        check_all();
        host.put(1'b1, 5'h03, 16'h0000, 0);
        repeat (2) @(posedge core_clk);
        #1;
        check(read_code, 10'(out_bank[3]));
        host.put(1'b1, 5'h14, 16'h0000, 0);
        host.put(1'b0, 5'h00, 16'h4001, 0);
        out_bank = first_bank;
        check_all();
        check({9'h000, otp_locked}, 10'h001);
        host.put(1'b1, 5'h05, 16'h0000, 0);
        host.put(1'b0, 5'h00, 16'h43FF, 0);
        check_all();
        stop_test();
    end
    initial begin
        #1000000;
        num_errors++;
        stop_test();
    end
endmodule
bind dbu_update dbu_update_properties chk (.core_clk, .srst, .otp_blank_init, .load_strobe_pin,
    .bus_start, .bus_addr, .bus_word, .bus_data, .addr_ack, .gamma_code_out,
    .common_electrode_out_a, .common_electrode_out_b, .otp_locked);
`default_nettype wire
